// *** rtl/mem_decode_cfg.svh ***
`ifndef MEM_DECODE_CFG_SVH
`define MEM_DECODE_CFG_SVH

// Whole space is 16-bit addressed
`define MD_ADDR_W 16
// Peripheral I/O block
`define MD_IO_LO 16'h0000
`define MD_IO_HI 16'h007F
// Gap before RAM
`define MD_GAP_HI 16'h008F
// Start of RAM and of the upper direct page
`define MD_RAM_LO 16'h0090
// Top of the unbanked direct page
`define MD_DIR_PAGE_HI 16'h00FF
// Largest banked direct limit
`define MD_DIR_MAX_HI 16'h047F
// Reduced banked limit, 512-byte RAM
`define MD_DIR_512_HI 16'h028F
// Reduced banked limit, smallest RAM
`define MD_DIR_256_HI 16'h018F
// Register area
`define MD_GPR_LO 16'h0100
`define MD_GPR_HI 16'h01FF
// Extended I/O block
`define MD_XIO_LO 16'h0F80
`define MD_XIO_HI 16'h0FFF
// Non-volatile register data
`define MD_NVR_LO 16'hFFBB
`define MD_NVR_HI 16'hFFBF
// Vector table
`define MD_VEC_LO 16'hFFC0
`define MD_VEC_HI 16'hFFFF
// Banked window geometry
`define MD_WIN_BASE 16'h0080
`define MD_WIN_SHIFT 7
// Bank pointer width and reset value
`define MD_BANK_W 3
`define MD_BANK_RST 3'h0

`endif

// *** rtl/mem_decode_pkg.sv ***
package mem_decode_pkg;

  // Region selected by an address, one-hot, zero when prohibited
  typedef enum logic [5:0] {
    RGN_NONE = 6'h00,
    RGN_IO = 6'h01,
    RGN_RAM = 6'h02,
    RGN_XIO = 6'h04,
    RGN_FLASH = 6'h08,
    RGN_NVR = 6'h10,
    RGN_VECTOR = 6'h20
  } region_e;

  // Plain 16-bit address
  typedef logic [15:0] addr_t;

endpackage

// *** rtl/addr_map_if.sv ***
`timescale 1ns/100ps
// Carries the requests and answers between the top and its helpers
interface addr_map_if;
  mem_decode_pkg::addr_t cls_addr; // Address to classify
  mem_decode_pkg::region_e cls_region; // Region found
  logic [7:0] dir_op; // Direct operand byte
  logic [2:0] dir_bank; // Bank pointer in use
  mem_decode_pkg::addr_t dir_addr; // Translated address
  logic dir_ok; // Translation lands in a real location

  modport classifier (input cls_addr, output cls_region);
  modport mapper (input dir_op, input dir_bank, output dir_addr, output dir_ok);
  modport user (output cls_addr, input cls_region, output dir_op, output dir_bank,
    input dir_addr, input dir_ok);
endinterface // addr_map_if

// *** rtl/region_classify.sv ***
`timescale 1ns/100ps
`include "mem_decode_cfg.svh"
// Sorts one address into its region
module region_classify #(
  parameter logic [15:0] RAM_HI = 16'h048F,
  parameter logic [15:0] FLASH_LO = 16'hC000
) (
  addr_map_if.classifier m
);

  // Priority: fixed regions first, unknown holes stay prohibited
  always_comb begin
    if (m.cls_addr <= `MD_IO_HI) begin
      m.cls_region = mem_decode_pkg::RGN_IO;
    end else if (m.cls_addr >= `MD_RAM_LO && m.cls_addr <= RAM_HI) begin
      m.cls_region = mem_decode_pkg::RGN_RAM;
    end else if (m.cls_addr >= `MD_XIO_LO && m.cls_addr <= `MD_XIO_HI) begin
      m.cls_region = mem_decode_pkg::RGN_XIO;
    end else if (m.cls_addr >= `MD_VEC_LO) begin
      m.cls_region = mem_decode_pkg::RGN_VECTOR;
    end else if (m.cls_addr >= `MD_NVR_LO) begin
      m.cls_region = mem_decode_pkg::RGN_NVR;
    end else if (m.cls_addr >= FLASH_LO) begin
      m.cls_region = mem_decode_pkg::RGN_FLASH;
    end else begin
      m.cls_region = mem_decode_pkg::RGN_NONE;
    end
  end

endmodule // region_classify

// *** rtl/direct_bank_map.sv ***
`timescale 1ns/100ps
`include "mem_decode_cfg.svh"
// Turns a direct operand and bank pointer into a full address
module direct_bank_map #(
  parameter logic [15:0] DIR_HI = 16'h047F
) (
  addr_map_if.mapper m
);

  logic [15:0] win_addr; // Address inside a banked window

  // Window n starts at base plus n times 128
  assign win_addr = `MD_WIN_BASE + {6'h00, m.dir_bank, m.dir_op[6:0]};

  // Lower operands ignore the bank, upper ones follow it
  always_comb begin
    if (!m.dir_op[7]) begin
      m.dir_addr = {8'h00, m.dir_op};
      m.dir_ok = 1'b1;
    end else if (m.dir_bank == `MD_BANK_RST) begin
      m.dir_addr = {8'h00, m.dir_op};
      m.dir_ok = ({8'h00, m.dir_op} >= `MD_RAM_LO);
    end else begin
      m.dir_addr = win_addr;
      m.dir_ok = (win_addr <= DIR_HI);
    end
  end

endmodule // direct_bank_map

// *** rtl/memory_space_decoder.sv ***
`timescale 1ns/100ps
`include "mem_decode_cfg.svh"
module memory_space_decoder #(
  parameter int RAM_BYTES = 1024,
  parameter logic [15:0] FLASH_LO = 16'hC000
) (
  input wire logic clk,
  input wire logic rst_n,
  // Ordinary memory access
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  // Direct operand access
  input wire logic dir_req,
  input wire logic [7:0] dir_op,
  // Register area access
  input wire logic gpr_req,
  input wire logic [4:0] gpr_bank,
  input wire logic [2:0] gpr_index,
  // Bank pointer write
  input wire logic bank_wr,
  input wire logic [2:0] bank_wdata,
  // Bank pointer now in force
  output logic [2:0] direct_bank_pointer,
  // Ordinary access answer
  output logic mem_valid,
  output mem_decode_pkg::region_e mem_region,
  output logic mem_prohibited,
  output logic mem_direct_reach,
  output logic mem_gpr_area,
  output logic [4:0] mem_vector_index,
  // Direct access answer
  output logic dir_valid,
  output logic [15:0] dir_addr,
  output mem_decode_pkg::region_e dir_region,
  output logic dir_prohibited,
  // Register area answer
  output logic gpr_valid,
  output logic [15:0] gpr_addr,
  output logic gpr_prohibited
);

  // Last RAM byte for this variant
  localparam logic [15:0] RAM_HI = 16'(`MD_RAM_LO + RAM_BYTES - 1);

  // Banked direct limit for this variant
  localparam logic [15:0] DIR_HI =
    (RAM_BYTES == 256) ? `MD_DIR_256_HI :
    (RAM_BYTES == 512) ? `MD_DIR_512_HI :
    `MD_DIR_MAX_HI;

  // Register area limit for this variant
  localparam logic [15:0] GPR_HI =
    (RAM_BYTES == 256) ? `MD_DIR_256_HI :
    `MD_GPR_HI;

  // Only the documented RAM sizes and a flash base above extended I/O
  generate
    if (RAM_BYTES != 256 && RAM_BYTES != 512 && RAM_BYTES != 1024) begin : g_bad_ram
      $error("RAM_BYTES must be 256, 512 or 1024");
    end
    if (FLASH_LO <= `MD_XIO_HI || FLASH_LO >= `MD_NVR_LO) begin : g_bad_flash
      $error("FLASH_LO must lie between extended I/O and NVR data");
    end
  endgenerate

  // Membership test used for several ranges
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Helper channel to the classifier and mapper
  addr_map_if u_if ();

  // Classifier for ordinary accesses only; direct answers take their region from the mapper
  region_classify #(
    .RAM_HI(RAM_HI),
    .FLASH_LO(FLASH_LO)
  ) u_classify (
    .m(u_if.classifier)
  );

  // Operand to address translation
  direct_bank_map #(
    .DIR_HI(DIR_HI)
  ) u_map (
    .m(u_if.mapper)
  );

  // ---- Bank pointer ----
  logic [2:0] bank_q; // Pointer held
  logic [2:0] bank_d; // Next pointer

  // Software write replaces the pointer
  always_comb begin
    bank_d = bank_q;
    // A write lands at this edge; direct operands see it a cycle later
    if (bank_wr) begin
      bank_d = bank_wdata;
    end
  end

  // Pointer register, cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Bank 0 maps upper operands one to one
      bank_q <= `MD_BANK_RST;
    end else begin
      bank_q <= bank_d;
    end
  end

  // Core reads the pointer as a registered level
  assign direct_bank_pointer = bank_q;

  // ---- Helper inputs ----
  // Direct operands use the pointer held before any same-cycle write
  assign u_if.dir_op = dir_op;
  assign u_if.dir_bank = bank_q;
  // Whole 16-bit address goes to the classifier
  assign u_if.cls_addr = mem_addr;

  // ---- Ordinary access decode ----
  logic mem_valid_q; // Answer strobe
  logic mem_valid_d;
  mem_decode_pkg::region_e mem_region_q; // Region found
  mem_decode_pkg::region_e mem_region_d;
  logic mem_prohibited_q; // No region selected
  logic mem_prohibited_d;
  logic mem_direct_q; // Also reachable by direct operand
  logic mem_direct_d;
  logic mem_gpr_q; // Falls in the register area
  logic mem_gpr_d;
  logic [4:0] mem_vec_q; // Vector slot number
  logic [4:0] mem_vec_d;

  // Next answer for an ordinary access
  always_comb begin
    mem_valid_d = mem_req;
    mem_region_d = mem_region_q;
    mem_prohibited_d = mem_prohibited_q;
    mem_direct_d = mem_direct_q;
    mem_gpr_d = mem_gpr_q;
    mem_vec_d = mem_vec_q;
    // Without a request the last answer stands
    if (mem_req) begin
      mem_region_d = u_if.cls_region;
      mem_prohibited_d = (u_if.cls_region == mem_decode_pkg::RGN_NONE);
      // I/O and lower RAM page answer to short direct operands
      mem_direct_d = in_range(mem_addr, `MD_IO_LO, `MD_IO_HI) ||
        in_range(mem_addr, `MD_RAM_LO, `MD_DIR_PAGE_HI);
      // Register area is part of RAM, limited per variant
      mem_gpr_d = in_range(mem_addr, `MD_GPR_LO, GPR_HI);
      // Two-byte vector entries, slot counted from the table base
      if (u_if.cls_region == mem_decode_pkg::RGN_VECTOR) begin
        mem_vec_d = mem_addr[5:1];
      end else begin
        // Outside the table the slot reads zero
        mem_vec_d = 5'h00;
      end
    end
  end

  // Ordinary access answer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Nothing answered yet, no region selected
      mem_valid_q <= 1'b0;
      mem_region_q <= mem_decode_pkg::RGN_NONE;
      mem_prohibited_q <= 1'b0;
      mem_direct_q <= 1'b0;
      mem_gpr_q <= 1'b0;
      mem_vec_q <= 5'h00;
    end else begin
      mem_valid_q <= mem_valid_d;
      mem_region_q <= mem_region_d;
      mem_prohibited_q <= mem_prohibited_d;
      mem_direct_q <= mem_direct_d;
      mem_gpr_q <= mem_gpr_d;
      mem_vec_q <= mem_vec_d;
    end
  end

  assign mem_valid = mem_valid_q;
  assign mem_region = mem_region_q;
  assign mem_prohibited = mem_prohibited_q;
  assign mem_direct_reach = mem_direct_q;
  assign mem_gpr_area = mem_gpr_q;
  assign mem_vector_index = mem_vec_q;

  // ---- Direct access decode ----
  logic dir_valid_q; // Answer strobe
  logic dir_valid_d;
  logic [15:0] dir_addr_q; // Translated address
  logic [15:0] dir_addr_d;
  mem_decode_pkg::region_e dir_region_q; // Region of the result
  mem_decode_pkg::region_e dir_region_d;
  logic dir_prohibited_q; // Operand lands nowhere
  logic dir_prohibited_d;

  // Next answer for a direct access
  always_comb begin
    dir_valid_d = dir_req;
    dir_addr_d = dir_addr_q;
    dir_region_d = dir_region_q;
    dir_prohibited_d = dir_prohibited_q;
    // Without a request the last answer stands
    if (dir_req) begin
      dir_addr_d = u_if.dir_addr;
      if (!u_if.dir_ok) begin
        // Gap below RAM or past the banked limit
        dir_region_d = mem_decode_pkg::RGN_NONE;
        dir_prohibited_d = 1'b1;
      end else if (!dir_op[7]) begin
        // Lower operand page is the I/O block
        dir_region_d = mem_decode_pkg::RGN_IO;
        dir_prohibited_d = 1'b0;
      end else begin
        // Upper operand lands in RAM, unbanked or windowed
        dir_region_d = mem_decode_pkg::RGN_RAM;
        dir_prohibited_d = 1'b0;
      end
    end
  end

  // Direct access answer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Nothing answered yet, no translation
      dir_valid_q <= 1'b0;
      dir_addr_q <= 16'h0000;
      dir_region_q <= mem_decode_pkg::RGN_NONE;
      dir_prohibited_q <= 1'b0;
    end else begin
      dir_valid_q <= dir_valid_d;
      dir_addr_q <= dir_addr_d;
      dir_region_q <= dir_region_d;
      dir_prohibited_q <= dir_prohibited_d;
    end
  end

  assign dir_valid = dir_valid_q;
  assign dir_addr = dir_addr_q;
  assign dir_region = dir_region_q;
  assign dir_prohibited = dir_prohibited_q;

  // ---- Register area decode ----
  logic gpr_valid_q; // Answer strobe
  logic gpr_valid_d;
  logic [15:0] gpr_addr_q; // RAM address of the register
  logic [15:0] gpr_addr_d;
  logic gpr_prohibited_q; // Register beyond the area
  logic gpr_prohibited_d;
  logic [15:0] gpr_raw; // Untested register address

  // Eight registers per bank, banks stacked from the area base
  assign gpr_raw = `MD_GPR_LO + {8'h00, gpr_bank, gpr_index};

  // Next answer for a register access
  always_comb begin
    gpr_valid_d = gpr_req;
    gpr_addr_d = gpr_addr_q;
    gpr_prohibited_d = gpr_prohibited_q;
    // Address is passed on even when it lies past the area
    if (gpr_req) begin
      gpr_addr_d = gpr_raw;
      gpr_prohibited_d = (gpr_raw > GPR_HI);
    end
  end

  // Register access answer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Nothing answered yet, no register address
      gpr_valid_q <= 1'b0;
      gpr_addr_q <= 16'h0000;
      gpr_prohibited_q <= 1'b0;
    end else begin
      gpr_valid_q <= gpr_valid_d;
      gpr_addr_q <= gpr_addr_d;
      gpr_prohibited_q <= gpr_prohibited_d;
    end
  end

  assign gpr_valid = gpr_valid_q;
  assign gpr_addr = gpr_addr_q;
  assign gpr_prohibited = gpr_prohibited_q;

endmodule // memory_space_decoder

// *** tb/mem_decode_chk.sv ***
`timescale 1ns/100ps
// Port-level relations of the decoder, one cycle from request to answer
module mem_decode_chk #(
  parameter int RAM_BYTES = 1024
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic dir_req,
  input wire logic [7:0] dir_op,
  input wire logic bank_wr,
  input wire logic [2:0] bank_wdata,
  input wire logic [2:0] direct_bank_pointer,
  input wire logic mem_valid,
  input mem_decode_pkg::region_e mem_region,
  input wire logic mem_prohibited,
  input wire logic mem_direct_reach,
  input wire logic mem_gpr_area,
  input wire logic [4:0] mem_vector_index,
  input wire logic [15:0] dir_addr,
  input mem_decode_pkg::region_e dir_region
);
  // Register area top shrinks on the smallest RAM
  localparam logic [15:0] GPR_HI = (RAM_BYTES == 256) ? 16'h018F : 16'h01FF;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_mem_answer: assert property (mem_req |=> mem_valid)
    else $error("mem answer missing");
  chk_mem_quiet: assert property (!mem_req |=> !mem_valid)
    else $error("mem answer without request");
  chk_io_region: assert property (mem_req && mem_addr <= 16'h007F |=>
    mem_region == mem_decode_pkg::RGN_IO && mem_direct_reach) else $error("io decode");
  chk_xio_region: assert property (mem_req && mem_addr inside {[16'h0F80:16'h0FFF]} |=>
    mem_region == mem_decode_pkg::RGN_XIO && !mem_direct_reach) else $error("xio decode");
  chk_gap_prohibited: assert property (mem_req && mem_addr inside {[16'h0080:16'h008F]} |=>
    mem_prohibited && mem_region == mem_decode_pkg::RGN_NONE) else $error("gap decode");
  chk_nvr_region: assert property (mem_req && mem_addr inside {[16'hFFBB:16'hFFBF]} |=>
    mem_region == mem_decode_pkg::RGN_NVR) else $error("nvr decode");
  chk_vector_slot: assert property (mem_req && mem_addr >= 16'hFFC0 |=>
    mem_region == mem_decode_pkg::RGN_VECTOR && mem_vector_index == $past(mem_addr[5:1]))
    else $error("vector decode");
  chk_gpr_window: assert property (mem_req |=>
    mem_gpr_area == ($past(mem_addr) inside {[16'h0100:GPR_HI]})) else $error("gpr area");
  chk_dir_lower: assert property (dir_req && dir_op < 8'h80 |=>
    dir_addr == {8'h00, $past(dir_op)} && dir_region == mem_decode_pkg::RGN_IO)
    else $error("lower direct map");
  chk_bank_load: assert property (bank_wr |=> direct_bank_pointer == $past(bank_wdata))
    else $error("bank pointer load");
  chk_bank_hold: assert property (!bank_wr |=> $stable(direct_bank_pointer))
    else $error("bank pointer drift");
endmodule // mem_decode_chk

// *** tb/cpu_access_model.sv ***
`timescale 1ns/100ps
// Core side: one-cycle requests, released lines show inverted values
module cpu_access_model (
  input wire logic clk,
  output logic mem_req,
  output logic [15:0] mem_addr,
  output logic dir_req,
  output logic [7:0] dir_op,
  output logic gpr_req,
  output logic [4:0] gpr_bank,
  output logic [2:0] gpr_index,
  output logic bank_wr,
  output logic [2:0] bank_wdata
);
  // Idle at time zero
  initial begin
    {mem_req, dir_req, gpr_req, bank_wr} = 4'h0;
    {mem_addr, dir_op, gpr_bank, gpr_index, bank_wdata} = '0;
  end
  // Ordinary access
  task automatic mem_acc(input logic [15:0] a);
    @(posedge clk);
    #1 mem_req = 1'b1;
    mem_addr = a;
    @(posedge clk);
    #1 mem_req = 1'b0;
    mem_addr = ~a;
  endtask
  // Direct operand access
  task automatic dir_acc(input logic [7:0] op);
    @(posedge clk);
    #1 dir_req = 1'b1;
    dir_op = op;
    @(posedge clk);
    #1 dir_req = 1'b0;
    dir_op = ~op;
  endtask
  // Register area access
  task automatic gpr_acc(input logic [4:0] b, input logic [2:0] i);
    @(posedge clk);
    #1 gpr_req = 1'b1;
    {gpr_bank, gpr_index} = {b, i};
    @(posedge clk);
    #1 gpr_req = 1'b0;
    {gpr_bank, gpr_index} = ~{b, i};
  endtask
  // Bank pointer write
  task automatic set_bank(input logic [2:0] v);
    @(posedge clk);
    #1 bank_wr = 1'b1;
    bank_wdata = v;
    @(posedge clk);
    #1 bank_wr = 1'b0;
    bank_wdata = ~v;
  endtask
endmodule // cpu_access_model

// *** tb/test_memory_space_decoder.sv ***
`timescale 1ns/100ps
// Self-checking bench for the decoder, default RAM size and both smaller sizes
module test_memory_space_decoder;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mem_req, dir_req, gpr_req, bank_wr, mem_valid, mem_prohibited, mem_direct_reach;
  logic mem_gpr_area, dir_valid, dir_prohibited, gpr_valid, gpr_prohibited;
  logic [15:0] mem_addr, dir_addr, gpr_addr;
  logic [7:0] dir_op;
  logic [4:0] gpr_bank, mem_vector_index;
  logic [2:0] gpr_index, bank_wdata, direct_bank_pointer;
  mem_decode_pkg::region_e mem_region, dir_region;
  // Answers of the smaller RAM variants, same stimulus
  mem_decode_pkg::region_e mem_region_256, dir_region_256, mem_region_512, dir_region_512;
  logic mem_gpr_area_256, dir_prohibited_256, gpr_prohibited_256, dir_prohibited_512;
  logic [15:0] dir_addr_256, gpr_addr_256, dir_addr_512;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #2.5 clk = ~clk;

  cpu_access_model u_cpu_access_model (.clk, .mem_req, .mem_addr, .dir_req, .dir_op,
    .gpr_req, .gpr_bank, .gpr_index, .bank_wr, .bank_wdata);
  memory_space_decoder u_memory_space_decoder (.clk, .rst_n, .mem_req, .mem_addr, .dir_req,
    .dir_op, .gpr_req, .gpr_bank, .gpr_index, .bank_wr, .bank_wdata, .direct_bank_pointer,
    .mem_valid, .mem_region, .mem_prohibited, .mem_direct_reach, .mem_gpr_area,
    .mem_vector_index, .dir_valid, .dir_addr, .dir_region, .dir_prohibited, .gpr_valid,
    .gpr_addr, .gpr_prohibited);
  // Smallest RAM variant
  memory_space_decoder #(.RAM_BYTES(256)) u_memory_space_decoder_256 (.clk, .rst_n, .mem_req,
    .mem_addr, .dir_req, .dir_op, .gpr_req, .gpr_bank, .gpr_index, .bank_wr, .bank_wdata,
    .direct_bank_pointer(), .mem_valid(), .mem_region(mem_region_256), .mem_prohibited(),
    .mem_direct_reach(), .mem_gpr_area(mem_gpr_area_256), .mem_vector_index(), .dir_valid(),
    .dir_addr(dir_addr_256), .dir_region(dir_region_256), .dir_prohibited(dir_prohibited_256),
    .gpr_valid(), .gpr_addr(gpr_addr_256), .gpr_prohibited(gpr_prohibited_256));
  // 512-byte RAM variant
  memory_space_decoder #(.RAM_BYTES(512)) u_memory_space_decoder_512 (.clk, .rst_n, .mem_req,
    .mem_addr, .dir_req, .dir_op, .gpr_req, .gpr_bank, .gpr_index, .bank_wr, .bank_wdata,
    .direct_bank_pointer(), .mem_valid(), .mem_region(mem_region_512), .mem_prohibited(),
    .mem_direct_reach(), .mem_gpr_area(), .mem_vector_index(), .dir_valid(),
    .dir_addr(dir_addr_512), .dir_region(dir_region_512), .dir_prohibited(dir_prohibited_512),
    .gpr_valid(), .gpr_addr(), .gpr_prohibited());

  // Compare and count
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      complete_run;
    end
  end

  task automatic t_reset;
    check("pointer", direct_bank_pointer, 16'h0000);
    check("mem_region", mem_region, 16'h0000);
  endtask

  // Region boundaries, every region code
  task automatic t_mem_map;
    logic [15:0] a [23];
    logic [5:0] r [23];
    logic [15:0] v;
    a = '{16'h0000, 16'h007F, 16'h0080, 16'h008F, 16'h0090, 16'h00FF, 16'h0100, 16'h01FF,
      16'h0200, 16'h048F, 16'h0490, 16'h0F7F, 16'h0F80, 16'h0FFF, 16'h1000, 16'hBFFF,
      16'hC000, 16'hFFBA, 16'hFFBB, 16'hFFBF, 16'hFFC0, 16'hFFC4, 16'hFFFF};
    r = '{6'h01, 6'h01, 6'h00, 6'h00, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h02, 6'h00,
      6'h00, 6'h04, 6'h04, 6'h00, 6'h00, 6'h08, 6'h08, 6'h10, 6'h10, 6'h20, 6'h20, 6'h20};
    for (int i = 0; i < 23; i++) begin
      v = a[i];
      u_cpu_access_model.mem_acc(v);
      check("mem_valid", mem_valid, 16'h0001);
      check("mem_region", mem_region, r[i]);
      check("mem_prohibited", mem_prohibited, r[i] == 6'h00);
      check("reach", mem_direct_reach, v <= 16'h007F || v inside {[16'h0090:16'h00FF]});
      check("gpr_area", mem_gpr_area, v inside {[16'h0100:16'h01FF]});
      check("vec", mem_vector_index, (r[i] == 6'h20) ? 5'((v - 16'hFFC0) >> 1) : 5'h00);
    end
  endtask

  // One direct access and its answer
  task automatic dir_one(input logic [7:0] op, input logic [15:0] ea, input logic [5:0] er);
    u_cpu_access_model.dir_acc(op);
    check("dir_valid", dir_valid, 16'h0001);
    check("dir_addr", dir_addr, ea);
    check("dir_region", dir_region, er);
    check("dir_prohibited", dir_prohibited, er == 6'h00);
  endtask

  // Bank pointer walk over all windows
  task automatic t_dir;
    logic [15:0] base;
    dir_one(8'h7F, 16'h007F, 6'h01);
    dir_one(8'h85, 16'h0085, 6'h00);
    dir_one(8'h90, 16'h0090, 6'h02);
    dir_one(8'hFF, 16'h00FF, 6'h02);
    for (int b = 1; b < 8; b++) begin
      base = 16'h0080 + 16'(b) * 16'h0080;
      u_cpu_access_model.set_bank(3'(b));
      check("pointer", direct_bank_pointer, 16'(b));
      dir_one(8'h80, base, 6'h02);
      dir_one(8'hFF, base + 16'h007F, 6'h02);
      dir_one(8'h00, 16'h0000, 6'h01);
    end
    u_cpu_access_model.set_bank(3'h0);
  endtask

  // Register area addressing
  task automatic t_gpr;
    u_cpu_access_model.gpr_acc(5'h02, 3'h5);
    check("gpr_valid", gpr_valid, 16'h0001);
    check("gpr_addr", gpr_addr, 16'h0115);
    u_cpu_access_model.gpr_acc(5'h1F, 3'h7);
    check("gpr_addr", gpr_addr, 16'h01FF);
    check("gpr_prohibited", gpr_prohibited, 16'h0000);
  endtask

  // Region ends of the two smaller RAM variants
  task automatic t_small;
    u_cpu_access_model.mem_acc(16'h018F);
    check("mem_region_256", mem_region_256, 16'h0002);
    check("gpr_area_256", mem_gpr_area_256, 16'h0001);
    u_cpu_access_model.mem_acc(16'h0190);
    check("mem_region_256", mem_region_256, 16'h0000);
    check("gpr_area_256", mem_gpr_area_256, 16'h0000);
    check("mem_region_512", mem_region_512, 16'h0002);
    u_cpu_access_model.mem_acc(16'h0290);
    check("mem_region_512", mem_region_512, 16'h0000);
    u_cpu_access_model.gpr_acc(5'h11, 3'h7);
    check("gpr_addr_256", gpr_addr_256, 16'h018F);
    check("gpr_prohibited_256", gpr_prohibited_256, 16'h0000);
    u_cpu_access_model.gpr_acc(5'h12, 3'h0);
    check("gpr_addr_256", gpr_addr_256, 16'h0190);
    check("gpr_prohibited_256", gpr_prohibited_256, 16'h0001);
    u_cpu_access_model.set_bank(3'h2);
    u_cpu_access_model.dir_acc(8'h8F);
    check("dir_addr_256", dir_addr_256, 16'h018F);
    check("dir_region_256", dir_region_256, 16'h0002);
    u_cpu_access_model.dir_acc(8'h90);
    check("dir_prohibited_256", dir_prohibited_256, 16'h0001);
    check("dir_region_256", dir_region_256, 16'h0000);
    u_cpu_access_model.set_bank(3'h4);
    u_cpu_access_model.dir_acc(8'h8F);
    check("dir_addr_512", dir_addr_512, 16'h028F);
    check("dir_prohibited_512", dir_prohibited_512, 16'h0000);
    u_cpu_access_model.dir_acc(8'h90);
    check("dir_prohibited_512", dir_prohibited_512, 16'h0001);
    check("dir_region_512", dir_region_512, 16'h0000);
    check("dir_prohibited", dir_prohibited, 16'h0000);
    u_cpu_access_model.set_bank(3'h0);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset;
    t_mem_map;
    t_dir;
    t_gpr;
    t_small;
    complete_run;
  end
endmodule // test_memory_space_decoder

bind memory_space_decoder mem_decode_chk #(.RAM_BYTES(RAM_BYTES)) u_mem_decode_chk (.clk(clk),
  .rst_n(rst_n), .mem_req(mem_req), .mem_addr(mem_addr), .dir_req(dir_req), .dir_op(dir_op),
  .bank_wr(bank_wr), .bank_wdata(bank_wdata), .direct_bank_pointer(direct_bank_pointer),
  .mem_valid(mem_valid), .mem_region(mem_region), .mem_prohibited(mem_prohibited),
  .mem_direct_reach(mem_direct_reach), .mem_gpr_area(mem_gpr_area),
  .mem_vector_index(mem_vector_index), .dir_addr(dir_addr), .dir_region(dir_region));
